// ---- desc_pkg.sv ----
// constants and types for the descriptor block
package desc_pkg;
    localparam logic [7:0] TYPE_STRING = 8'h03;
    localparam logic [7:0] TYPE_INTERFACE = 8'h04;
    localparam logic [7:0] TYPE_ENDPOINT = 8'h05;
    localparam logic [7:0] LEN_INTERFACE = 8'h09;
    localparam logic [7:0] LEN_ENDPOINT = 8'h07;
    localparam logic [7:0] LEN_LANG = 8'h04;
    localparam logic [7:0] NUM_ENDPOINTS = 8'h03;
    localparam logic [7:0] EP_DIR_IN = 8'h80;
    localparam logic [7:0] EP1_ADDR = 8'h81;
    localparam logic [7:0] EP2_ADDR = 8'h02;
    localparam logic [7:0] EP3_ADDR = 8'h83;
    localparam logic [1:0] XFER_CONTROL = 2'h0;
    localparam logic [1:0] XFER_ISO = 2'h1;
    localparam logic [1:0] XFER_BULK = 2'h2;
    localparam logic [1:0] XFER_INTR = 2'h3;
    localparam logic [15:0] BULK_MPS_FS = 16'h0040;
    localparam logic [15:0] BULK_MPS_HS = 16'h0200;
    localparam logic [15:0] INTR_MPS = 16'h0008;
    localparam logic [7:0] BULK_INTERVAL_RST = 8'h00;
    localparam logic [7:0] INTR_INTERVAL = 8'h01;
    localparam logic [7:0] INTR_INTERVAL_MAX = 8'hFF;
    localparam logic [15:0] LANG_ENGLISH = 16'h0409;
    localparam logic [3:0] INTR_STATUS_LEN = 4'h8;
    typedef enum logic [2:0] {
        SEL_INTERFACE, SEL_EP1, SEL_EP2, SEL_EP3, SEL_LANG
    } desc_sel_e;
    typedef struct packed {
        logic valid;
        logic [2:0] sel;
        logic [7:0] length;
    } desc_req_s;
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } desc_byte_s;
endpackage

// ---- usb_descriptors.sv ----
// interface, endpoint and language descriptor source plus interrupt poll
module usb_descriptors (
    input wire logic clk,
    input wire logic rst,
    input wire desc_pkg::desc_req_s req,
    input wire logic byte_ready,
    output desc_pkg::desc_byte_s out_byte,
    output logic busy,
    input wire logic high_speed,
    input wire logic eeprom_loaded,
    input wire logic [7:0] eeprom_interval,
    input wire logic intr_poll,
    input wire logic intr_pending,
    input wire logic [63:0] intr_status,
    output logic intr_nak,
    output desc_pkg::desc_byte_s intr_byte
);
    logic [2:0] sel;
    logic [7:0] idx;
    logic [7:0] remain;
    logic [7:0] bulk_interval;
    logic [7:0] next_data;
    logic [7:0] desc_len;
    logic [63:0] intr_shift;
    logic [3:0] intr_cnt;

    // interval register follows the EEPROM once loaded
    always_ff @(posedge clk) begin
        if (rst) begin
            bulk_interval <= desc_pkg::BULK_INTERVAL_RST;
        end else if (eeprom_loaded) begin
            bulk_interval <= eeprom_interval;
        end
    end

    function automatic logic [7:0] ep_byte(input logic [7:0] i,
                                           input logic [7:0] addr,
                                           input logic [1:0] xfer,
                                           input logic [15:0] mps,
                                           input logic [7:0] intv);
        unique case (i)
            8'h00: ep_byte = desc_pkg::LEN_ENDPOINT;
            8'h01: ep_byte = desc_pkg::TYPE_ENDPOINT;
            8'h02: ep_byte = addr;
            8'h03: ep_byte = {6'h00, xfer};
            8'h04: ep_byte = mps[7:0];
            8'h05: ep_byte = mps[15:8];
            default: ep_byte = intv;
        endcase
    endfunction

    logic [15:0] bulk_mps;
    assign bulk_mps = high_speed ? desc_pkg::BULK_MPS_HS
                                 : desc_pkg::BULK_MPS_FS;

    always_comb begin
        next_data = 8'h00;
        desc_len = desc_pkg::LEN_ENDPOINT;
        unique case (sel)
            desc_pkg::SEL_INTERFACE: begin
                desc_len = desc_pkg::LEN_INTERFACE;
                unique case (idx)
                    8'h00: next_data = desc_pkg::LEN_INTERFACE;
                    8'h01: next_data = desc_pkg::TYPE_INTERFACE;
                    8'h04: next_data = desc_pkg::NUM_ENDPOINTS;
                    default: next_data = 8'h00;
                endcase
            end
            desc_pkg::SEL_EP1: next_data = ep_byte(idx, desc_pkg::EP1_ADDR,
                desc_pkg::XFER_BULK, bulk_mps, bulk_interval);
            desc_pkg::SEL_EP2: next_data = ep_byte(idx, desc_pkg::EP2_ADDR,
                desc_pkg::XFER_BULK, bulk_mps, bulk_interval);
            desc_pkg::SEL_EP3: next_data = ep_byte(idx, desc_pkg::EP3_ADDR,
                desc_pkg::XFER_INTR, desc_pkg::INTR_MPS,
                desc_pkg::INTR_INTERVAL);
            desc_pkg::SEL_LANG: begin
                desc_len = desc_pkg::LEN_LANG;
                unique case (idx)
                    8'h00: next_data = desc_pkg::LEN_LANG;
                    8'h01: next_data = desc_pkg::TYPE_STRING;
                    8'h02: next_data = desc_pkg::LANG_ENGLISH[7:0];
                    default: next_data = desc_pkg::LANG_ENGLISH[15:8];
                endcase
            end
            default: next_data = 8'h00;
        endcase
    end

    // stream: one byte per accepted beat; a shown byte only advances on ready
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            sel <= 3'h0;
            idx <= 8'h00;
            remain <= 8'h00;
            out_byte <= '0;
        end else if (!busy) begin
            if (req.valid && req.length != 8'h00) begin
                busy <= 1'b1;
                sel <= req.sel;
                idx <= 8'h00;
                remain <= req.length;
            end
        end else if (!out_byte.valid || byte_ready) begin
            // a zero remainder or the end of the table closes the transfer
            if (remain == 8'h00 || idx == desc_len) begin
                out_byte <= '0;
                busy <= out_byte.valid && !byte_ready;
            end else begin
                out_byte.valid <= 1'b1;
                out_byte.data <= next_data;
                out_byte.last <= remain == 8'h01 ||
                                 idx == desc_len - 8'h01;
                idx <= idx + 8'h01;
                remain <= remain - 8'h01;
            end
        end
    end

    // interrupt endpoint: nak when idle, else eight status bytes
    always_ff @(posedge clk) begin
        if (rst) begin
            intr_nak <= 1'b0;
            intr_cnt <= 4'h0;
            intr_shift <= 64'h0;
            intr_byte <= '0;
        end else begin
            intr_nak <= intr_poll && !intr_pending &&
                        intr_cnt == 4'h0;
            if (intr_cnt == 4'h0) begin
                intr_byte <= '0;
                if (intr_poll && intr_pending) begin
                    intr_shift <= intr_status;
                    intr_cnt <= desc_pkg::INTR_STATUS_LEN;
                end
            end else begin
                intr_byte.valid <= 1'b1;
                intr_byte.data <= intr_shift[7:0]; // byte 0 first
                intr_byte.last <= intr_cnt == 4'h1;
                intr_shift <= {8'h00, intr_shift[63:8]};
                intr_cnt <= intr_cnt - 4'h1;
            end
        end
    end

    chk_lang_id: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid && sel == desc_pkg::SEL_LANG && idx == 8'h03
        |-> out_byte.data == desc_pkg::LANG_ENGLISH[7:0])
        else $error("language id low byte wrong");
    chk_bulk_speed: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid && sel == desc_pkg::SEL_EP1 && idx == 8'h06
        && $stable(high_speed)
        |-> out_byte.data == (high_speed ? 8'h02 : 8'h00))
        else $error("bulk packet size high byte wrong");
    chk_ep_addr: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid && idx == 8'h03 && sel != desc_pkg::SEL_INTERFACE
        && sel != desc_pkg::SEL_LANG |-> out_byte.data[6:4] == 3'h0)
        else $error("endpoint address reserved bits set");
    chk_ep3_attr: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid && sel == desc_pkg::SEL_EP3 && idx == 8'h04
        |-> out_byte.data == 8'h03)
        else $error("interrupt attribute wrong");
    chk_intf_count: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid && sel == desc_pkg::SEL_INTERFACE && idx == 8'h05
        |-> out_byte.data == desc_pkg::NUM_ENDPOINTS)
        else $error("endpoint count wrong");
    chk_intr_ivl: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid && sel == desc_pkg::SEL_EP3 && idx == 8'h07
        |-> out_byte.data == 8'h01)
        else $error("interrupt interval wrong");
    chk_bulk_ivl: assert property (@(posedge clk) disable iff (rst)
        eeprom_loaded ##1 !eeprom_loaded |-> bulk_interval ==
        $past(eeprom_interval, 1))
        else $error("bulk interval not loaded");
    chk_trunc_len: assert property (@(posedge clk) disable iff (rst)
        !busy && req.valid && req.length == 8'h02
        |-> ##[1:40] (out_byte.valid && out_byte.last) ##1 !out_byte.valid
        [*2])
        else $error("truncated transfer wrong");
    chk_intr_nak: assert property (@(posedge clk) disable iff (rst)
        intr_poll && !intr_pending && intr_cnt == 4'h0 |=> intr_nak)
        else $error("missing nak on idle poll");
    chk_intr_len: assert property (@(posedge clk) disable iff (rst)
        intr_poll && intr_pending && intr_cnt == 4'h0
        |=> ##1 intr_byte.valid [*8] ##1 !intr_byte.valid)
        else $error("status burst not eight bytes");
    chk_ep1_addr: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid && sel == desc_pkg::SEL_EP1 && idx == 8'h03
        |-> out_byte.data == desc_pkg::EP1_ADDR)
        else $error("ep1 address wrong");
    // idx already points one past the byte on show, hence the offsets
    chk_ep2_addr: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid && sel == desc_pkg::SEL_EP2 && idx == 8'h03
        |-> out_byte.data == desc_pkg::EP2_ADDR)
        else $error("ep2 address wrong");
    chk_ep_dir: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid && idx == 8'h03 && (sel == desc_pkg::SEL_EP1 ||
        sel == desc_pkg::SEL_EP2 || sel == desc_pkg::SEL_EP3)
        |-> out_byte.data[7] == (sel != desc_pkg::SEL_EP2))
        else $error("endpoint direction bit wrong");
    chk_bulk_attr: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid && idx == 8'h04 && (sel == desc_pkg::SEL_EP1 ||
        sel == desc_pkg::SEL_EP2)
        |-> out_byte.data == {6'h00, desc_pkg::XFER_BULK})
        else $error("bulk attribute wrong");
    chk_intf_len: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid && sel == desc_pkg::SEL_INTERFACE && idx == 8'h01
        |-> out_byte.data == desc_pkg::LEN_INTERFACE)
        else $error("interface length wrong");
    // a byte left on show after busy drops would leak into the next table
    chk_valid_busy: assert property (@(posedge clk) disable iff (rst)
        out_byte.valid |-> busy)
        else $error("byte shown while idle");
    chk_nak_excl: assert property (@(posedge clk) disable iff (rst)
        intr_nak |-> !intr_byte.valid)
        else $error("nak and status byte together");

    cov_lang: cover property (@(posedge clk)
        out_byte.valid && out_byte.last && sel == desc_pkg::SEL_LANG);
    cov_hs_ep2: cover property (@(posedge clk)
        high_speed && out_byte.valid && sel == desc_pkg::SEL_EP2);
    cov_intr: cover property (@(posedge clk)
        intr_byte.valid && intr_byte.last);
    cov_nak: cover property (@(posedge clk) intr_nak);
    cov_trunc: cover property (@(posedge clk)
        out_byte.valid && out_byte.last && remain == 8'h00 && idx != desc_len);
endmodule // usb_descriptors

// ---- usb_host_sink.sv ----
// host-side consumer of descriptor bytes, prompt or slow
module usb_host_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    output logic byte_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase;
    // slow mode takes one byte in three, so held bytes get exercised
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= 2'h0;
            byte_ready <= 1'b0;
        end else begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            byte_ready <= !slow || phase == 2'h2;
        end
    end
endmodule // usb_host_sink

// ---- tb.sv ----
// self-checking bench for the descriptor source and interrupt poll
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, byte_ready, busy, high_speed, eeprom_loaded, slow, hs;
    logic intr_poll, intr_pending, intr_nak;
    logic [7:0] eeprom_interval, intv;
    logic [63:0] intr_status;
    logic [15:0] rnd;
    desc_pkg::desc_req_s req;
    desc_pkg::desc_byte_s out_byte, intr_byte;
    logic [8:0] exp_q[$];
    logic [8:0] intr_q[$];
    int miscompares, num_checks;
    usb_descriptors uut (.clk(clk), .rst(rst), .req(req),
        .byte_ready(byte_ready), .out_byte(out_byte), .busy(busy),
        .high_speed(high_speed), .eeprom_loaded(eeprom_loaded),
        .eeprom_interval(eeprom_interval), .intr_poll(intr_poll),
        .intr_pending(intr_pending), .intr_status(intr_status),
        .intr_nak(intr_nak), .intr_byte(intr_byte));
    usb_host_sink host (.clk(clk), .rst(rst), .slow(slow),
        .byte_ready(byte_ready));
    function automatic logic [15:0] lfsr(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [7:0] dbyte(int sel, int i);
        logic [15:0] m;
        logic [7:0] e [7];
        m = hs ? 16'h0200 : 16'h0040;
        if (sel == 0) return (i == 0) ? 8'h09 : (i == 1) ? 8'h04 :
            (i == 4) ? 8'h03 : 8'h00;
        if (sel == 4) return (i == 0) ? 8'h04 : (i == 1) ? 8'h03 :
            (i == 2) ? 8'h09 : 8'h04;
        e = '{8'h07, 8'h05, 8'h81, 8'h02, m[7:0], m[15:8], intv};
        if (sel == 2) e[2] = 8'h02;
        if (sel == 3) e = '{8'h07, 8'h05, 8'h83, 8'h03, 8'h08, 8'h00,
            8'h01};
        return e[i];
    endfunction
    task automatic fetch(int sel, logic [7:0] len);
        int n;
        n = (sel == 0) ? 9 : (sel == 4) ? 4 : 7;
        if (len < n) n = len;
        for (int i = 0; i < n; i++)
            exp_q.push_back({i == n - 1, dbyte(sel, i)});
        req <= '{1'b1, 3'(sel), len};
        @(posedge clk);
        req <= '0;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
        num_checks++;
        if (busy !== 1'b0) begin
            miscompares++;
            $display("ERROR %0t busy stuck", $time);
        end
    endtask
    task automatic poll(logic pend, logic [63:0] st);
        for (int i = 0; i < 8 && pend; i++)
            intr_q.push_back({i == 7, st[8*i+:8]});
        intr_pending <= pend;
        intr_status <= st;
        intr_poll <= 1'b1;
        @(posedge clk);
        intr_poll <= 1'b0;
        #1;
        num_checks++;
        if (intr_nak !== !pend) begin
            miscompares++;
            $display("ERROR %0t nak wrong", $time);
        end
        repeat (11) @(posedge clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (!rst && out_byte.valid === 1'b1 && byte_ready === 1'b1) begin
            num_checks++;
            if (exp_q.size() == 0 || {out_byte.last, out_byte.data}
                    !== exp_q[0]) begin
                miscompares++;
                $display("ERROR %0t descriptor byte %h", $time, out_byte.data);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
        if (!rst && intr_byte.valid === 1'b1) begin
            num_checks++;
            if (intr_q.size() == 0 || {intr_byte.last, intr_byte.data}
                    !== intr_q[0]) begin
                miscompares++;
                $display("ERROR %0t status byte %h", $time, intr_byte.data);
            end
            if (intr_q.size() != 0) void'(intr_q.pop_front());
        end
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400000;
        miscompares++;
        $display("ERROR %0t watchdog", $time);
        report_and_stop();
    end
    initial begin
        rst = 1'b1;
        req = '0;
        slow = 1'b0;
        high_speed = 1'b0;
        hs = 1'b0;
        eeprom_loaded = 1'b0;
        eeprom_interval = 8'h00;
        intr_poll = 1'b0;
        intr_pending = 1'b0;
        intr_status = '0;
        intv = 8'h00;
        rnd = 16'h9016;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // four rounds: full speed, high speed, loaded interval, cut lengths
        for (int r = 0; r < 4; r++) begin
            hs = r[0];
            high_speed <= hs;
            if (r == 2) begin
                rnd = lfsr(rnd);
                intv = rnd[7:0];
                eeprom_interval <= intv;
                eeprom_loaded <= 1'b1;
                @(posedge clk);
                eeprom_loaded <= 1'b0;
            end
            for (int s = 0; s < 5; s++) begin
                rnd = lfsr(rnd);
                slow <= rnd[4];
                fetch(s, (r == 3) ? 8'(rnd[3:0]) : 8'hFF);
            end
        end
        fetch(4, 8'h00);
        fetch(0, 8'h01);
        // a two-byte cut is always exercised, whatever the random lengths
        fetch(3, 8'h02);
        for (int p = 0; p < 4; p++) begin
            rnd = lfsr(rnd);
            poll(p[0], {rnd, ~rnd, lfsr(rnd), rnd ^ 16'h5A5A});
        end
        num_checks++;
        if (exp_q.size() != 0 || intr_q.size() != 0) begin
            miscompares++;
            $display("ERROR %0t bytes missing", $time);
        end
        report_and_stop();
    end
endmodule // tb
